// >>> rtl/spims_pkg.sv
// Constants, register map and field layout of the serial port in SPI mode.
// Assumes an Avalon-MM word-addressed register bus and one module clock that also
// serves as the bit-rate source clock.
//
// Contract
// - SPI runs only with synchronous mode set
// - Master drives master-out; slave reads it
// - Master samples master-in; slave drives it
// - Clock pin output as master, input as slave
// - Pin mode sets transfer-enable polarity and meaning
// - Three-pin operation ignores the transfer-enable pin
// - Power-up clear sets the software reset bit
// - Reset bit clears enables, errors; sets transmit flag
// - Clearing reset bit releases normal operation
// - Characters are seven or eight bits
// - Seven-bit receive data right-aligned, top bit zero
// - Bit order selectable, least-significant first by default
// - Master transmit buffer write starts a transfer
// - Capture on edge opposite to data change
// - Full character goes to receive buffer, flag set
// - Transmit flag set when buffer moves to shifter
// - Clock polarity and phase separately selectable
// - Flag register: bit1 transmit, bit0 receive
// - Transmit buffer write clears the transmit flag
// - Receive buffer read clears the receive flag
// - Master bit clock is source over 16-bit divisor; divisors below two run as two
// - Four-pin master inactive: release, error, abort; error and abort only while a character shifts
package spims_pkg;

  // ---------------------------------------------------------------------------
  // Register word addresses.
  // ---------------------------------------------------------------------------
  localparam logic [3:0] SPIMS_ADDR_CTRL = 4'h0;
  localparam logic [3:0] SPIMS_ADDR_RESET = 4'h1;
  localparam logic [3:0] SPIMS_ADDR_DIV_LO = 4'h2;
  localparam logic [3:0] SPIMS_ADDR_DIV_HI = 4'h3;
  localparam logic [3:0] SPIMS_ADDR_STATUS = 4'h4;
  localparam logic [3:0] SPIMS_ADDR_RXBUF = 4'h5;
  localparam logic [3:0] SPIMS_ADDR_TXBUF = 4'h6;
  localparam logic [3:0] SPIMS_ADDR_IRQ_EN = 4'h7;
  localparam logic [3:0] SPIMS_ADDR_IRQ_FLAGS = 4'h8;

  // ---------------------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------------------
  localparam int SPIMS_CTRL_SYNC = 0;
  localparam int SPIMS_CTRL_MODE_LO = 1;
  localparam int SPIMS_CTRL_MODE_HI = 2;
  localparam int SPIMS_CTRL_MASTER = 3;
  localparam int SPIMS_CTRL_SEVEN = 4;
  localparam int SPIMS_CTRL_MSB = 5;
  localparam int SPIMS_CTRL_PHASE = 6;
  localparam int SPIMS_CTRL_POL = 7;
  localparam int SPIMS_RESET_BIT = 0;
  localparam int SPIMS_STAT_BUSY = 0;
  localparam int SPIMS_STAT_OVERRUN = 5;
  localparam int SPIMS_STAT_CONFLICT = 6;
  localparam int SPIMS_FLAG_RX = 0;
  localparam int SPIMS_FLAG_TX = 1;

  // ---------------------------------------------------------------------------
  // Encodings, reset values and counts.
  // ---------------------------------------------------------------------------
  localparam logic [1:0] SPIMS_PINS_3 = 2'h0;
  localparam logic [1:0] SPIMS_PINS_4_HIGH = 2'h1;
  localparam logic [1:0] SPIMS_PINS_4_LOW = 2'h2;
  localparam logic [7:0] SPIMS_CTRL_RESET = 8'h00;
  localparam logic [15:0] SPIMS_DIV_RESET = 16'h0000;
  localparam logic [15:0] SPIMS_DIV_MIN = 16'h0002;
  localparam logic [3:0] SPIMS_LEN_7 = 4'h7;
  localparam logic [3:0] SPIMS_LEN_8 = 4'h8;

  typedef enum logic [1:0] {
    SPIMS_IDLE = 2'b01,
    SPIMS_SHIFT = 2'b10
  } spims_state_e;

endpackage : spims_pkg

// >>> rtl/spims_port.sv
// Serial port in SPI mode: register slave, master bit clock generator, shift engine.
// Assumes pin inputs synchronous to clk and an external resolver for the
// three-signal pins (input, output, output enable).
`timescale 1ns/1ps

module spims_port
  import spims_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic master_out_line_i,
  output logic master_out_line_o,
  output logic master_out_line_oe,
  input wire logic master_in_line_i,
  output logic master_in_line_o,
  output logic master_in_line_oe,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  input wire logic transfer_enable_pin,
  output logic transmit_irq,
  output logic receive_irq
);

  // ---------------------------------------------------------------------------
  // Helper functions.
  // ---------------------------------------------------------------------------

  // Bit presented on the data line for the current shifter contents.
  function automatic logic out_bit(input logic [7:0] sh, input logic msb, input logic seven);
    logic b;
    b = msb ? (seven ? sh[6] : sh[7]) : sh[0];
    return b;
  endfunction : out_bit

  // Advance the transmit shifter by one position.
  function automatic logic [7:0] shift_out(input logic [7:0] sh, input logic msb);
    logic [7:0] r;
    r = msb ? {sh[6:0], 1'b0} : {1'b0, sh[7:1]};
    return r;
  endfunction : shift_out

  // Bring a received character into buffer alignment.
  function automatic logic [7:0] rx_align(input logic [7:0] sh, input logic msb,
                                          input logic seven);
    logic [7:0] r;
    if (!seven) begin
      r = sh;
    end else if (msb) begin
      r = {1'b0, sh[6:0]};
    end else begin
      r = {1'b0, sh[7:1]};
    end
    return r;
  endfunction : rx_align

  // ---------------------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic swrst;
    logic [15:0] div;
    logic rx_ie;
    logic tx_ie;
    logic tx_flag;
    logic rx_flag;
    logic overrun;
    logic conflict;
    logic [7:0] txbuf;
    logic tx_full;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic [7:0] rxbuf;
    logic [3:0] bits;
    logic [15:0] div_cnt;
    logic sclk;
    logic mosi;
    logic miso;
    logic sclk_prev;
    spims_state_e state;
    logic ack;
    logic [31:0] rdata;
  } spims_regs_s;

  spims_regs_s q;
  spims_regs_s d;
  logic rst_meta_q;
  logic rst_sync_q;

  // Reset release through two flip-flops; assertion stays asynchronous.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Decoded configuration.
  // ---------------------------------------------------------------------------
  logic enabled;
  logic is_master;
  logic seven;
  logic msb;
  logic phase;
  logic pol;
  logic [1:0] pins;
  logic slave_active;
  logic master_active;
  logic [15:0] div_eff;
  logic [15:0] half_cnt;
  logic [3:0] char_len;

  always_comb begin
    enabled = q.ctrl[SPIMS_CTRL_SYNC] & ~q.swrst;
    is_master = q.ctrl[SPIMS_CTRL_MASTER];
    seven = q.ctrl[SPIMS_CTRL_SEVEN];
    msb = q.ctrl[SPIMS_CTRL_MSB];
    phase = q.ctrl[SPIMS_CTRL_PHASE];
    pol = q.ctrl[SPIMS_CTRL_POL];
    pins = q.ctrl[SPIMS_CTRL_MODE_HI:SPIMS_CTRL_MODE_LO];
    char_len = seven ? SPIMS_LEN_7 : SPIMS_LEN_8;
    // Pin level meaning per pin mode; three-pin mode never looks at the pin.
    unique case (pins)
      SPIMS_PINS_4_HIGH: slave_active = transfer_enable_pin;
      SPIMS_PINS_4_LOW: slave_active = ~transfer_enable_pin;
      default: slave_active = 1'b1;
    endcase
    master_active = (pins == SPIMS_PINS_3) ? 1'b1 : ~slave_active;
    // Divisors below two cannot make two clock edges per bit, so they run at two.
    div_eff = (q.div < SPIMS_DIV_MIN) ? SPIMS_DIV_MIN : q.div;
    half_cnt = div_eff >> 1;
  end

  // ---------------------------------------------------------------------------
  // Next-state logic.
  // ---------------------------------------------------------------------------
  logic req;
  logic take;
  logic lead_ev;
  logic trail_ev;
  logic capture_ev;
  logic change_ev;
  logic din;
  logic [3:0] bits_next;
  logic [7:0] wbyte;

  always_comb begin
    d = q;
    req = avs_read | avs_write;
    take = req & q.ack;
    wbyte = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
    lead_ev = 1'b0;
    trail_ev = 1'b0;
    bits_next = q.bits;
    din = is_master ? master_in_line_i : master_out_line_i;

    // Bus slave: one wait cycle, read data registered at the first edge.
    d.ack = req & ~q.ack;
    if (req && !q.ack) begin
      d.rdata = 32'h0000_0000;
      unique case (avs_address)
        SPIMS_ADDR_CTRL: d.rdata[7:0] = q.ctrl;
        SPIMS_ADDR_RESET: d.rdata[SPIMS_RESET_BIT] = q.swrst;
        SPIMS_ADDR_DIV_LO: d.rdata[7:0] = q.div[7:0];
        SPIMS_ADDR_DIV_HI: d.rdata[7:0] = q.div[15:8];
        SPIMS_ADDR_STATUS: begin
          d.rdata[SPIMS_STAT_BUSY] = (q.state == SPIMS_SHIFT);
          d.rdata[SPIMS_STAT_OVERRUN] = q.overrun;
          d.rdata[SPIMS_STAT_CONFLICT] = q.conflict;
        end
        SPIMS_ADDR_RXBUF: d.rdata[7:0] = q.rxbuf;
        SPIMS_ADDR_TXBUF: d.rdata[7:0] = q.txbuf;
        SPIMS_ADDR_IRQ_EN: begin
          d.rdata[SPIMS_FLAG_RX] = q.rx_ie;
          d.rdata[SPIMS_FLAG_TX] = q.tx_ie;
        end
        SPIMS_ADDR_IRQ_FLAGS: begin
          d.rdata[SPIMS_FLAG_RX] = q.rx_flag;
          d.rdata[SPIMS_FLAG_TX] = q.tx_flag;
        end
        default: d.rdata = 32'h0000_0000;
      endcase
    end

    // Software writes take effect at the acceptance edge; hardware sets follow
    // below so that a set in the same cycle wins over the clear.
    if (take && avs_write && avs_byteenable[0]) begin
      unique case (avs_address)
        SPIMS_ADDR_CTRL: d.ctrl = wbyte;
        SPIMS_ADDR_RESET: d.swrst = wbyte[SPIMS_RESET_BIT];
        SPIMS_ADDR_DIV_LO: d.div[7:0] = wbyte;
        SPIMS_ADDR_DIV_HI: d.div[15:8] = wbyte;
        SPIMS_ADDR_STATUS: begin
          d.overrun = wbyte[SPIMS_STAT_OVERRUN];
          d.conflict = wbyte[SPIMS_STAT_CONFLICT];
        end
        SPIMS_ADDR_TXBUF: begin
          d.txbuf = wbyte;
          d.tx_full = 1'b1;
          d.tx_flag = 1'b0;
        end
        SPIMS_ADDR_IRQ_EN: begin
          d.rx_ie = wbyte[SPIMS_FLAG_RX];
          d.tx_ie = wbyte[SPIMS_FLAG_TX];
        end
        SPIMS_ADDR_IRQ_FLAGS: begin
          d.rx_flag = wbyte[SPIMS_FLAG_RX];
          d.tx_flag = wbyte[SPIMS_FLAG_TX];
        end
        default: d.ctrl = q.ctrl;
      endcase
    end
    if (take && avs_read && avs_address == SPIMS_ADDR_RXBUF) begin
      d.rx_flag = 1'b0;
    end

    // Clock edge events: generated in master role, seen on the pin as slave.
    d.sclk_prev = serial_clock_pin_i;
    if (is_master) begin
      if (q.state == SPIMS_SHIFT) begin
        d.div_cnt = q.div_cnt + 16'h0001;
        lead_ev = (q.div_cnt == half_cnt - 16'h0001);
        trail_ev = (q.div_cnt == div_eff - 16'h0001);
        if (trail_ev) begin
          d.div_cnt = 16'h0000;
        end
      end
    end else begin
      lead_ev = (serial_clock_pin_i != q.sclk_prev) && (q.sclk_prev == pol);
      trail_ev = (serial_clock_pin_i != q.sclk_prev) && (q.sclk_prev != pol);
    end
    capture_ev = phase ? lead_ev : trail_ev;
    change_ev = phase ? trail_ev : lead_ev;

    // Shift engine.
    unique case (q.state)
      SPIMS_IDLE: begin
        d.sclk = pol;
        d.div_cnt = 16'h0000;
        d.bits = 4'h0;
        if (enabled && q.tx_full && (!is_master || master_active)) begin
          d.tx_sh = q.txbuf;
          d.tx_full = 1'b0;
          d.tx_flag = 1'b1;
          d.state = SPIMS_SHIFT;
          if (phase) begin
            d.mosi = is_master ? out_bit(q.txbuf, msb, seven) : q.mosi;
            d.miso = is_master ? q.miso : out_bit(q.txbuf, msb, seven);
          end
        end else if (enabled && !is_master && slave_active && (lead_ev || trail_ev)) begin
          // A slave clocked with nothing loaded still receives; it sends zeros.
          d.tx_sh = 8'h00;
          d.state = SPIMS_SHIFT;
        end
      end
      SPIMS_SHIFT: begin
        if (is_master && lead_ev) begin
          d.sclk = ~pol;
        end
        if (is_master && trail_ev) begin
          d.sclk = pol;
        end
        if (!is_master && !slave_active) begin
          // Halted slave ignores the clock until selected again.
          capture_ev = 1'b0;
          change_ev = 1'b0;
          trail_ev = 1'b0;
        end
        if (change_ev && phase && q.bits != char_len) begin
          d.tx_sh = shift_out(q.tx_sh, msb);
          if (is_master) begin
            d.mosi = out_bit(d.tx_sh, msb, seven);
          end else begin
            d.miso = out_bit(d.tx_sh, msb, seven);
          end
        end else if (change_ev && !phase) begin
          if (is_master) begin
            d.mosi = out_bit(q.tx_sh, msb, seven);
          end else begin
            d.miso = out_bit(q.tx_sh, msb, seven);
          end
          d.tx_sh = shift_out(q.tx_sh, msb);
        end
        if (capture_ev) begin
          d.rx_sh = msb ? {q.rx_sh[6:0], din} : {din, q.rx_sh[7:1]};
          bits_next = q.bits + 4'h1;
          d.bits = bits_next;
        end
        if (trail_ev && bits_next == char_len) begin
          d.rxbuf = rx_align(d.rx_sh, msb, seven);
          d.overrun = q.overrun | q.rx_flag;
          d.rx_flag = 1'b1;
          d.bits = 4'h0;
          d.div_cnt = 16'h0000;
          d.state = SPIMS_IDLE;
        end
      end
      default: d.state = SPIMS_IDLE;
    endcase

    // Four-pin master pushed inactive: abort the character and flag a conflict.
    if (enabled && is_master && !master_active && q.state == SPIMS_SHIFT) begin
      d.conflict = 1'b1;
      d.state = SPIMS_IDLE;
      d.bits = 4'h0;
      d.div_cnt = 16'h0000;
      d.sclk = pol;
    end

    // Software reset, also the state after power-up clear.
    if (!q.ctrl[SPIMS_CTRL_SYNC] || q.swrst) begin
      d.state = SPIMS_IDLE;
      d.bits = 4'h0;
      d.div_cnt = 16'h0000;
      d.tx_full = 1'b0;
      d.sclk = pol;
    end
    if (q.swrst) begin
      d.rx_ie = 1'b0;
      d.tx_ie = 1'b0;
      d.rx_flag = 1'b0;
      d.overrun = 1'b0;
      d.conflict = 1'b0;
      d.tx_flag = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // State register.
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      q.ctrl <= SPIMS_CTRL_RESET;
      q.swrst <= 1'b1;
      q.div <= SPIMS_DIV_RESET;
      q.rx_ie <= 1'b0;
      q.tx_ie <= 1'b0;
      q.tx_flag <= 1'b1;
      q.rx_flag <= 1'b0;
      q.overrun <= 1'b0;
      q.conflict <= 1'b0;
      q.txbuf <= 8'h00;
      q.tx_full <= 1'b0;
      q.tx_sh <= 8'h00;
      q.rx_sh <= 8'h00;
      q.rxbuf <= 8'h00;
      q.bits <= 4'h0;
      q.div_cnt <= 16'h0000;
      q.sclk <= 1'b0;
      q.mosi <= 1'b0;
      q.miso <= 1'b0;
      q.sclk_prev <= 1'b0;
      q.state <= SPIMS_IDLE;
      q.ack <= 1'b0;
      q.rdata <= 32'h0000_0000;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs.
  // ---------------------------------------------------------------------------

  // Pins are released whenever the role, pin mode or reset says so.
  always_comb begin
    avs_readdata = q.rdata;
    avs_waitrequest = (avs_read | avs_write) & ~q.ack;
    master_out_line_o = q.mosi;
    master_out_line_oe = enabled & is_master & master_active;
    serial_clock_pin_o = q.sclk;
    serial_clock_pin_oe = enabled & is_master & master_active;
    master_in_line_o = q.miso;
    master_in_line_oe = enabled & ~is_master & slave_active;
    transmit_irq = q.tx_flag & q.tx_ie;
    receive_irq = q.rx_flag & q.rx_ie;
  end

endmodule : spims_port

// >>> tb/spims_port_assertions.sv
// Checker for the SPI-mode port: bus handshake, pin roles and flag clearing.
// Assumes it is bound to spims_port and sees only that module's ports.
`timescale 1ns/1ps
module spims_port_assertions
  import spims_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic master_out_line_oe,
  input wire logic master_in_line_oe,
  input wire logic serial_clock_pin_oe,
  input wire logic transfer_enable_pin,
  input wire logic transmit_irq,
  input wire logic receive_irq
);
  // ----------------------------------
  // Shadow configuration
  // ----------------------------------
  logic [7:0] ctrl_q;
  logic srst_q;
  logic [2:0] age_q;
  wire acc = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire on = ctrl_q[0] && !srst_q;
  wire mst = on && ctrl_q[3];
  wire [1:0] md = ctrl_q[2:1];
  wire inact = (md == SPIMS_PINS_4_HIGH && transfer_enable_pin) ||
               (md == SPIMS_PINS_4_LOW && !transfer_enable_pin);
  // The age counter lets checks wait until a new setting has settled.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= 8'h00;
      srst_q <= 1'b1;
      age_q <= 3'h0;
    end else begin
      if (acc && avs_address == SPIMS_ADDR_CTRL) ctrl_q <= avs_writedata[7:0];
      if (acc && avs_address == SPIMS_ADDR_RESET) srst_q <= avs_writedata[0];
      if (acc && avs_address < 4'h2) age_q <= 3'h0;
      else if (age_q != 3'h7) age_q <= age_q + 3'h1;
    end
  end
  // ----------------------------------
  // Properties
  // ----------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("register access held more than one wait cycle");
  a_mosi_role: assert property (master_out_line_oe |-> mst || $past(mst))
    else $error("master-out driven outside enabled master role");
  a_miso_role: assert property (master_in_line_oe |->
    (on && !ctrl_q[3]) || $past(on && !ctrl_q[3]))
    else $error("master-in driven outside enabled slave role");
  a_clk_pair: assert property (serial_clock_pin_oe == master_out_line_oe)
    else $error("clock pin drive differs from master-out drive");
  a_three_pin: assert property (age_q == 3'h7 && mst && md == SPIMS_PINS_3
    && master_out_line_oe && $changed(transfer_enable_pin) |=> master_out_line_oe)
    else $error("three-pin master reacted to transfer-enable");
  a_ste_release: assert property (mst && inact |->
    !master_out_line_oe && !serial_clock_pin_oe)
    else $error("inactive master kept driving the bus");
  a_reset_quiet: assert property (srst_q && age_q == 3'h7 |-> !transmit_irq && !receive_irq)
    else $error("interrupt request under software reset");
  a_rx_clear: assert property (avs_read && !avs_waitrequest
    && avs_address == SPIMS_ADDR_RXBUF |=> !receive_irq)
    else $error("receive request survived a buffer read");
  a_tx_clear: assert property (acc && avs_address == SPIMS_ADDR_TXBUF |=> !transmit_irq)
    else $error("transmit request survived a buffer write");
  c_rx_done: cover property ($rose(receive_irq));
  c_conflict: cover property (mst && inact && $past(master_out_line_oe));
  c_slave: cover property (master_in_line_oe);
endmodule : spims_port_assertions

bind spims_port spims_port_assertions u_spims_port_assertions (
  .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .master_out_line_oe(master_out_line_oe),
  .master_in_line_oe(master_in_line_oe), .serial_clock_pin_oe(serial_clock_pin_oe),
  .transfer_enable_pin(transfer_enable_pin), .transmit_irq(transmit_irq),
  .receive_irq(receive_irq));

// >>> tb/spims_peer.sv
// Behavioural SPI slave on the port's serial side, always selected.
// Assumes the clock idles at pol between exchanges; clr starts a new one.
`timescale 1ns/1ps
module spims_peer (
  input wire logic clk,
  input wire logic clr,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic pol,
  input wire logic phase,
  input wire logic msb,
  input wire logic seven,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte,
  output int period,
  output int frames
);
  logic [7:0] sh = 8'h00;
  logic [3:0] oi = 4'h0;
  logic [3:0] ci = 4'h0;
  logic lead;
  int cyc = 0;
  int last = 0;
  function automatic logic [3:0] nxt(input logic [3:0] i);
    return (i == (seven ? 4'h6 : 4'h7)) ? 4'h0 : i + 4'h1;
  endfunction : nxt
  // Bit position of the i-th bit on the wire.
  function automatic logic [2:0] pos(input logic [3:0] i);
    return msb ? 3'((seven ? 4'h6 : 4'h7) - i) : i[2:0];
  endfunction : pos
  initial begin
    period = 0;
    frames = 0;
    rx_byte = 8'h00;
  end
  // Cycle count, used only to time the leading edges.
  always @(posedge clk) cyc <= cyc + 1;
  assign miso = tx_byte[pos(oi)];
  // Without phase the first change edge brings bit 0, so start one before it.
  always @(posedge clr) begin
    ci = 4'h0;
    oi = phase ? 4'h0 : (seven ? 4'h6 : 4'h7);
  end
  // Capture and change sit on opposite clock edges, chosen by phase.
  always @(sclk) begin
    lead = (sclk !== pol);
    if (lead) begin
      period = cyc - last;
      last = cyc;
    end
    if (lead == phase) begin
      sh[pos(ci)] = mosi;
      ci = nxt(ci);
      if (ci == 4'h0) begin
        rx_byte = sh & (seven ? 8'h7f : 8'hff);
        frames++;
      end
    end else begin
      oi = nxt(oi);
    end
  end
endmodule : spims_peer

// >>> tb/spims_port_tb_top.sv
// Self-checking bench: register bus driver, read-data monitor and SPI slave peer.
// Assumes the port's one-wait-cycle bus and a 250 MHz module clock.
`timescale 1ns/1ps
module spims_port_tb_top
  import spims_pkg::*;
();
  logic clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, clr = 1'b0, ste = 1'b0;
  logic [3:0] adr = 4'h0, be = 4'h1;
  logic [31:0] wd = 32'h0, rdat;
  logic wait_b, mo, moe, mi, mie, so, soe, tx_irq, rx_irq, miso;
  logic mo_last = 1'b0, so_last = 1'b0, pol = 1'b0, pha = 1'b0, msb = 1'b0, sev = 1'b0;
  logic [7:0] ptx = 8'h00, prx, mk, m, c, xs;
  logic xen = 1'b0, xclk = 1'b0, xmo = 1'b0;
  int fail_count = 0, total_checks = 0, per, frames, n, d, f;
  logic [31:0] q_exp[$];
  string q_nm[$];
  always #2 clk = ~clk;
  // Released pins show the bench master's levels when xen is set, else the inverse of their last level, never a stale copy.
  wire mosi_w = moe ? mo : xen ? xmo : ~mo_last;
  wire sclk_w = soe ? so : xen ? xclk : ~so_last;
  always @(posedge clk) begin
    if (moe) mo_last <= mo;
    if (soe) so_last <= so;
  end
  spims_port u_spims_port (.clk(clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wait_b), .master_out_line_i(mosi_w), .master_out_line_o(mo),
    .master_out_line_oe(moe), .master_in_line_i(miso), .master_in_line_o(mi),
    .master_in_line_oe(mie), .serial_clock_pin_i(sclk_w), .serial_clock_pin_o(so),
    .serial_clock_pin_oe(soe), .transfer_enable_pin(ste), .transmit_irq(tx_irq),
    .receive_irq(rx_irq));
  spims_peer u_spims_peer (.clk(clk), .clr(clr), .sclk(sclk_w), .mosi(mosi_w), .pol(pol),
    .phase(pha), .msb(msb), .seven(sev), .tx_byte(ptx), .miso(miso), .rx_byte(prx),
    .period(per), .frames(frames));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // Every conditional wait passes through here, so a hang ends in the verdict.
  task automatic guard(inout int k);
    @(posedge clk);
    k++;
    if (k > 2000) begin
      fail_count++;
      $display("MISMATCH timeout expected 0 seen %0d", k);
      print_verdict();
    end
  endtask : guard
  // One bus cycle, held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] dat);
    int k;
    k = 0;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= {24'h0, dat};
    do guard(k); while (wait_b !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic rd_exp(input logic [3:0] a, input logic [31:0] e);
    q_exp.push_back(e);
    q_nm.push_back($sformatf("reg%0h", a));
    bus(1'b0, a, 8'h00);
  endtask : rd_exp
  task automatic setup(input logic [7:0] cf, input logic [7:0] dv);
    bus(1'b1, SPIMS_ADDR_RESET, 8'h01);
    bus(1'b1, SPIMS_ADDR_CTRL, cf);
    bus(1'b1, SPIMS_ADDR_DIV_LO, dv);
    bus(1'b1, SPIMS_ADDR_DIV_HI, 8'h00);
    bus(1'b1, SPIMS_ADDR_RESET, 8'h00);
    repeat (2) @(posedge clk);
  endtask : setup
  // The oldest expectation is compared at the edge that returns read data.
  always @(posedge clk) begin
    if (rd && wait_b === 1'b0) begin
      if (q_exp.size() == 0) chk("queue", 32'h1, 32'h0);
      else chk(q_nm.pop_front(), q_exp.pop_front(), rdat);
    end
  end
  initial begin
    void'($urandom(55933));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd_exp(SPIMS_ADDR_RESET, 32'h1);
    rd_exp(SPIMS_ADDR_IRQ_FLAGS, 32'h2);
    rd_exp(SPIMS_ADDR_CTRL, 32'h0);
    rd_exp(4'hf, 32'h0);
    bus(1'b1, SPIMS_ADDR_RESET, 8'h00);
    bus(1'b1, SPIMS_ADDR_IRQ_EN, 8'h03);
    @(posedge clk);
    chk("tx_irq", 32'h1, tx_irq);
    bus(1'b1, SPIMS_ADDR_RESET, 8'h01);
    rd_exp(SPIMS_ADDR_IRQ_EN, 32'h0);
    rd_exp(SPIMS_ADDR_STATUS, 32'h0);
    chk("tx_irq", 32'h0, tx_irq);
    setup(8'h08, 8'h02);
    chk("mosi_oe", 32'h0, moe);
    setup(8'h01, 8'h02);
    chk("roles", 32'h4, {mie, moe, soe});
    // Every polarity, phase and order in three-pin master mode.
    for (int i = 0; i < 9; i++) begin
      m = 8'($urandom);
      c = {i[2:0], 1'($urandom_range(1)), 4'b1001};
      mk = c[4] ? 8'h7f : 8'hff;
      {pol, pha, msb, sev} <= c[7:4];
      ptx <= 8'($urandom);
      d = 2 + i % 3;
      setup(c, 8'(d));
      bus(1'b1, SPIMS_ADDR_IRQ_EN, 8'h03);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      bus(1'b1, SPIMS_ADDR_TXBUF, m);
      n = 0;
      while (rx_irq !== 1'b1) begin
        ste <= 1'($urandom_range(1));
        guard(n);
      end
      rd_exp(SPIMS_ADDR_RXBUF, {24'h0, ptx & mk});
      rd_exp(SPIMS_ADDR_IRQ_FLAGS, 32'h2);
      chk("peer_rx", {24'h0, m & mk}, {24'h0, prx});
      chk("period", d, per);
      chk("sclk_idle", i[2], so);
      chk("tx_irq", 32'h1, tx_irq);
    end
    // Two characters back to back, the second queued while the first shifts.
    f = frames;
    bus(1'b1, SPIMS_ADDR_TXBUF, 8'h5a);
    bus(1'b1, SPIMS_ADDR_TXBUF, 8'ha5);
    rd_exp(SPIMS_ADDR_IRQ_FLAGS, 32'h0);
    n = 0;
    while (frames != f + 2) guard(n);
    repeat (2) @(posedge clk);
    rd_exp(SPIMS_ADDR_STATUS, 32'h20);
    rd_exp(SPIMS_ADDR_RXBUF, {24'h0, ptx & mk});
    // Both four-pin polarities, each aborted in mid-character.
    for (int k = 1; k < 3; k++) begin
      ste <= (k == 2);
      {pol, pha, msb, sev} <= 4'h0;
      setup({5'h01, 2'(k), 1'b1}, 8'h04);
      bus(1'b1, SPIMS_ADDR_TXBUF, 8'h3c);
      n = 0;
      while (so !== 1'b1) guard(n);
      ste <= (k == 1);
      repeat (4) @(posedge clk);
      chk("oe", 32'h0, {moe, soe});
      rd_exp(SPIMS_ADDR_STATUS, 32'h40);
    end
    // Slave role, mode 0, LSB first: the bench plays the external master.
    xen <= 1'b1;
    setup(8'h01, 8'h02);
    m = 8'($urandom);
    bus(1'b1, SPIMS_ADDR_TXBUF, m);
    for (int b = 0; b < 8; b++) begin
      repeat (3) @(posedge clk);
      xmo <= ~m[b];
      xclk <= 1'b1;
      repeat (3) @(posedge clk);
      xs[b] = mi;
      xclk <= 1'b0;
    end
    chk("slave_tx", {24'h0, m}, {24'h0, xs});
    rd_exp(SPIMS_ADDR_RXBUF, {24'h0, ~m});
    print_verdict();
  end
endmodule : spims_port_tb_top
